// ==== src/ppgu_defs.vh ====
// Purpose: constants for the pulse pattern next-data upper block
// Assumes: 32-bit Avalon-MM, byte address = 4 * register index
// Notes: register values sit in bits 7:0, bits 31:8 read zero
//
// Overview of operation
// - group 2 select 00/01/1x picks timer 0/1/2
// - group 3 select 00/01/1x picks timer 0/1/2
// - upper enable bit gates output and transfer
// - lower enable bit gates output and port A transfer
// - next bits 15:8 go to port B 7:0
// - next bits 7:0 go to port A 7:0
// - shared trigger: both groups in first byte
// - split trigger: group 3 first, group 2 second
`ifndef PPGU_DEFS_VH
`define PPGU_DEFS_VH

`define PPGU_ADDR_W 22
`define PPGU_IDX_W 20

// register indices
`define PPGU_IDX_ENABLE_UPPER 20'hFFFA2
`define PPGU_IDX_ENABLE_LOWER 20'hFFFA3
`define PPGU_IDX_NEXT_UPPER_SHARED 20'hFFFA4
`define PPGU_IDX_NEXT_LOWER_SHARED 20'hFFFA5
`define PPGU_IDX_NEXT_UPPER_GROUP2 20'hFFFA6
`define PPGU_IDX_NEXT_LOWER_GROUP0 20'hFFFA7
`define PPGU_IDX_TRIG_SEL 20'hFFFA8

// trigger select field positions, two bits per group
`define PPGU_TRIG_G0_LSB 0
`define PPGU_TRIG_G1_LSB 2
`define PPGU_TRIG_G2_LSB 4
`define PPGU_TRIG_G3_LSB 6

// trigger select codes
`define PPGU_SEL_CH0 2'h0
`define PPGU_SEL_CH1 2'h1

// reset values
`define PPGU_RST_ENABLE 8'h00
`define PPGU_RST_TRIG_SEL 8'h00
`define PPGU_RST_NEXT 4'h0
`define PPGU_RST_PINS 8'h00
`define PPGU_RST_RDATA 32'h00000000

// answer latency in clock edges from request to waitrequest low
`define PPGU_ACK_CYCLES 1

`endif

// ==== src/ppgu_top.v ====
// Purpose: next-data enables, trigger routing and pattern pins
// Assumes: compare match inputs are one-cycle pulses on clk
// Notes: one wait state on every access, unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none
`include "ppgu_defs.vh"

module ppgu_top (
   input wire clk,
   input wire sys_rst,
   input wire [`PPGU_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [2:0] cmp_match,
   output reg [7:0] porta_out,
   output reg [7:0] portb_out,
   output reg [7:0] porta_tpc_en,
   output reg [7:0] portb_tpc_en
);

   // bus state
   reg [31:0] rdata_d;
   wire req;
   wire take;
   wire [`PPGU_IDX_W-1:0] idx;
   wire lane0;
   wire wr_ok;

   // registers
   reg [7:0] en_upper_q;
   reg [7:0] en_lower_q;
   reg [7:0] trig_sel_q;
   reg [3:0] nd_q [0:3];

   // decoded strobes
   wire hit_en_upper;
   wire hit_en_lower;
   wire hit_trig;
   wire hit_up_first;
   wire hit_lo_first;
   wire hit_up_second;
   wire hit_lo_second;

   // per group decode
   wire [3:0] grp_trig;
   wire [1:0] grp_chan [0:3];
   wire shared_upper;
   wire shared_lower;
   wire [15:0] en_all;
   wire [15:0] pins_q;

   // code 1x always means timer 2, so a torn 10 entry cannot misroute
   function [1:0] ppgu_chan;
      input [1:0] code;
      begin
         if (code == `PPGU_SEL_CH0) begin
            ppgu_chan = 2'h0;
         end else if (code == `PPGU_SEL_CH1) begin
            ppgu_chan = 2'h1;
         end else begin
            ppgu_chan = 2'h2;
         end
      end
   endfunction

   assign req = avs_read | avs_write;
   // the access completes on the edge that sees waitrequest low
   assign take = req & ~avs_waitrequest;
   assign idx = avs_address[`PPGU_ADDR_W-1:2];
   assign lane0 = avs_byteenable[0];
   assign wr_ok = take & avs_write & lane0;

   assign hit_en_upper = (idx == `PPGU_IDX_ENABLE_UPPER);
   assign hit_en_lower = (idx == `PPGU_IDX_ENABLE_LOWER);
   assign hit_trig = (idx == `PPGU_IDX_TRIG_SEL);
   assign hit_up_first = (idx == `PPGU_IDX_NEXT_UPPER_SHARED);
   assign hit_lo_first = (idx == `PPGU_IDX_NEXT_LOWER_SHARED);
   assign hit_up_second = (idx == `PPGU_IDX_NEXT_UPPER_GROUP2);
   assign hit_lo_second = (idx == `PPGU_IDX_NEXT_LOWER_GROUP0);

   // group channel decode
   assign grp_chan[0] = ppgu_chan(trig_sel_q[`PPGU_TRIG_G0_LSB+1:`PPGU_TRIG_G0_LSB]);
   assign grp_chan[1] = ppgu_chan(trig_sel_q[`PPGU_TRIG_G1_LSB+1:`PPGU_TRIG_G1_LSB]);
   assign grp_chan[2] = ppgu_chan(trig_sel_q[`PPGU_TRIG_G2_LSB+1:`PPGU_TRIG_G2_LSB]);
   assign grp_chan[3] = ppgu_chan(trig_sel_q[`PPGU_TRIG_G3_LSB+1:`PPGU_TRIG_G3_LSB]);

   // sharing is judged on the decoded channel, so codes 10 and 11 match
   assign shared_upper = (grp_chan[2] == grp_chan[3]);
   assign shared_lower = (grp_chan[0] == grp_chan[1]);

   assign en_all = {en_upper_q, en_lower_q};
   assign pins_q = {portb_out, porta_out};

   // bus handshake: one wait state, then one cycle of waitrequest low
   always @(posedge clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else if (req & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read mux, loaded while the answer is being prepared
   always @* begin
      rdata_d = `PPGU_RST_RDATA;
      if (hit_en_upper) begin
         rdata_d[7:0] = en_upper_q;
      end else if (hit_en_lower) begin
         rdata_d[7:0] = en_lower_q;
      end else if (hit_trig) begin
         rdata_d[7:0] = trig_sel_q;
      end else if (hit_up_first) begin
         rdata_d[7:0] = shared_upper ? {nd_q[3], nd_q[2]} : {nd_q[3], 4'h0};
      end else if (hit_up_second) begin
         rdata_d[7:0] = shared_upper ? 8'h00 : {4'h0, nd_q[2]};
      end else if (hit_lo_first) begin
         rdata_d[7:0] = shared_lower ? {nd_q[1], nd_q[0]} : {nd_q[1], 4'h0};
      end else if (hit_lo_second) begin
         rdata_d[7:0] = shared_lower ? 8'h00 : {4'h0, nd_q[0]};
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         avs_readdata <= `PPGU_RST_RDATA;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= rdata_d;
      end
   end

   // control registers
   always @(posedge clk) begin
      if (sys_rst) begin
         en_upper_q <= `PPGU_RST_ENABLE;
         en_lower_q <= `PPGU_RST_ENABLE;
         trig_sel_q <= `PPGU_RST_TRIG_SEL;
      end else begin
         if (wr_ok & hit_en_upper) begin
            en_upper_q <= avs_writedata[7:0];
         end
         if (wr_ok & hit_en_lower) begin
            en_lower_q <= avs_writedata[7:0];
         end
         if (wr_ok & hit_trig) begin
            trig_sel_q <= avs_writedata[7:0];
         end
      end
   end

   // enables also drive the pin function select, both from flip-flops
   always @(posedge clk) begin
      if (sys_rst) begin
         porta_tpc_en <= `PPGU_RST_ENABLE;
         portb_tpc_en <= `PPGU_RST_ENABLE;
      end else begin
         porta_tpc_en <= en_lower_q;
         portb_tpc_en <= en_upper_q;
      end
   end

   // per group: trigger pick, next-data storage and pin transfer
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : grp
         wire is_odd;
         wire shared;
         wire hit_first;
         wire hit_second;
         wire wr_grp;
         wire [3:0] wr_val;
         reg [3:0] pin_d;

         assign is_odd = (g % 2) == 1;
         assign shared = (g >= 2) ? shared_upper : shared_lower;
         assign hit_first = (g >= 2) ? hit_up_first : hit_lo_first;
         assign hit_second = (g >= 2) ? hit_up_second : hit_lo_second;

         // odd group always lives in the high nibble of the first byte;
         // even group joins it only when both share a trigger
         assign wr_grp = is_odd ? (wr_ok & hit_first) :
            (shared ? (wr_ok & hit_first) : (wr_ok & hit_second));
         assign wr_val = is_odd ? avs_writedata[7:4] : avs_writedata[3:0];

         assign grp_trig[g] = cmp_match[grp_chan[g]];

         always @(posedge clk) begin
            if (sys_rst) begin
               nd_q[g] <= `PPGU_RST_NEXT;
            end else if (wr_grp) begin
               nd_q[g] <= wr_val;
            end
         end

         // a write in the trigger cycle is missed by that match
         always @* begin
            pin_d = pins_q[g*4+3:g*4];
            if (grp_trig[g]) begin
               pin_d = (nd_q[g] & en_all[g*4+3:g*4]) |
                  (pins_q[g*4+3:g*4] & ~en_all[g*4+3:g*4]);
            end
         end
      end
   endgenerate

   // pins in the same bit order as the next-data bits
   always @(posedge clk) begin
      if (sys_rst) begin
         porta_out <= `PPGU_RST_PINS;
         portb_out <= `PPGU_RST_PINS;
      end else begin
         porta_out <= {grp[1].pin_d, grp[0].pin_d};
         portb_out <= {grp[3].pin_d, grp[2].pin_d};
      end
   end

endmodule
`default_nettype wire

// ==== dv/ppgu_monitor.sv ====
// Purpose: port checker for ppgu_top
// Assumes: one clock, synchronous reset
// Notes: sees ports only, so group routing is left to the bench
`timescale 1ns/1ps
`default_nettype none
module ppgu_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic [2:0] cmp_match,
   input wire logic [7:0] porta_out,
   input wire logic [7:0] portb_out,
   input wire logic [7:0] porta_tpc_en,
   input wire logic [7:0] portb_tpc_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic req = avs_read | avs_write;
   property p_ack; req && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer held too long");
   property p_why; $fell(avs_waitrequest) |-> $past(req); endproperty
   a_why: assert property (p_why) else $error("answer without request");
   property p_rdz; avs_readdata[31:8] == 24'h000000; endproperty
   a_rdz: assert property (p_rdz) else $error("read data upper bits set");
   // pins may move only on the edge that samples a compare match
   property p_hold; !$past(|cmp_match) |-> $stable({porta_out, portb_out}); endproperty
   a_hold: assert property (p_hold) else $error("pins moved without trigger");
   property p_gta; ((porta_out ^ $past(porta_out)) & ~porta_tpc_en) == 8'h00; endproperty
   a_gta: assert property (p_gta) else $error("disabled port A pin moved");
   property p_gtb; ((portb_out ^ $past(portb_out)) & ~portb_tpc_en) == 8'h00; endproperty
   a_gtb: assert property (p_gtb) else $error("disabled port B pin moved");
   // the pin enable trails the register by one edge, so the write is two edges back
   property p_ena; $changed(porta_tpc_en) |-> $past(avs_write && !avs_waitrequest, 2); endproperty
   a_ena: assert property (p_ena) else $error("port A enable moved alone");
   property p_enb; $changed(portb_tpc_en) |-> $past(avs_write && !avs_waitrequest, 2); endproperty
   a_enb: assert property (p_enb) else $error("port B enable moved alone");
   c_trig: cover property (|cmp_match);
   c_rd: cover property (avs_read && !avs_waitrequest);
   c_wr: cover property (avs_write && !avs_waitrequest);
endmodule
bind ppgu_top ppgu_monitor u_mon (.clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
   .avs_readdata, .cmp_match, .porta_out, .portb_out, .porta_tpc_en, .portb_tpc_en);
`default_nettype wire

// ==== dv/ppgu_pins.sv ====
// Purpose: circuitry on the port A and B pins
// Assumes: a set pattern enable means the unit drives the pin
// Notes: an undriven pin shows the inverse level so it never passes by luck
`timescale 1ns/1ps
`default_nettype none
module ppgu_pins (
   input wire logic [7:0] porta_out,
   input wire logic [7:0] portb_out,
   input wire logic [7:0] porta_tpc_en,
   input wire logic [7:0] portb_tpc_en,
   output logic [7:0] pin_a,
   output logic [7:0] pin_b
);
   assign pin_a = porta_out ^ ~porta_tpc_en;
   assign pin_b = portb_out ^ ~portb_tpc_en;
endmodule
`default_nettype wire

// ==== dv/ppgu_top_tb.sv ====
// Purpose: self-checking bench for ppgu_top
// Assumes: waits are bounded, no fixed answer latency relied on
// Notes: rows build on each other since pins hold between triggers
`timescale 1ns/1ps
`default_nettype none
`include "ppgu_defs.vh"
module ppgu_top_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [21:0] avs_address = 22'h000000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [2:0] cmp_match = 3'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] porta_out, portb_out, porta_tpc_en, portb_tpc_en, pin_a, pin_b, q;
   int failures = 0;
   int comparisons = 0;
   // select, enable, shared byte, group 2 byte, channel, port B
   logic [41:0] rows [8] = '{{8'h00, 8'hFF, 8'hA5, 8'h3C, 2'd0, 8'hA5},
      {8'h50, 8'h0F, 8'h3C, 8'hFF, 2'd1, 8'hAC}, {8'h20, 8'hFF, 8'h96, 8'h07, 2'd2, 8'hA7},
      {8'h30, 8'hFF, 8'hE1, 8'h02, 2'd0, 8'hE7}, {8'h80, 8'hFF, 8'h58, 8'h0B, 2'd2, 8'h57},
      {8'hD0, 8'hFF, 8'h30, 8'h0D, 2'd1, 8'h5D}, {8'h40, 8'hFF, 8'hF0, 8'h06, 2'd1, 8'hFD},
      {8'hE0, 8'hF0, 8'h12, 8'hFF, 2'd2, 8'h1D}};
   ppgu_top dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmp_match, .porta_out, .portb_out,
      .porta_tpc_en, .portb_tpc_en);
   ppgu_pins far (.porta_out, .portb_out, .porta_tpc_en, .portb_tpc_en, .pin_a, .pin_b);
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic summarize;
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [19:0] i, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= {i, 2'b00};
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         failures++;
         summarize();
      end
   endtask
   task automatic trig(input int ch);
      @(posedge clk);
      cmp_match <= 3'h1 << ch;
      @(posedge clk);
      cmp_match <= 3'h0;
      @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[k]) begin
         acc(1'b1, `PPGU_IDX_TRIG_SEL, rows[k][41:34]);
         acc(1'b1, `PPGU_IDX_ENABLE_UPPER, rows[k][33:26]);
         acc(1'b1, `PPGU_IDX_NEXT_UPPER_SHARED, rows[k][25:18]);
         acc(1'b1, `PPGU_IDX_NEXT_UPPER_GROUP2, rows[k][17:10]);
         trig(rows[k][9:8]);
         chk(portb_out, rows[k][7:0]);
      end
      acc(1'b0, `PPGU_IDX_NEXT_UPPER_SHARED, 8'h00);
      chk(q, 8'h12);
      acc(1'b0, `PPGU_IDX_NEXT_UPPER_GROUP2, 8'h00);
      chk(q, 8'h00);
      avs_byteenable <= 4'hE;
      acc(1'b1, `PPGU_IDX_ENABLE_UPPER, 8'h55);
      avs_byteenable <= 4'hF;
      acc(1'b0, `PPGU_IDX_ENABLE_UPPER, 8'h00);
      chk(q, 8'hF0);
      acc(1'b0, 20'h00010, 8'h00);
      chk(q, 8'h00);
      acc(1'b1, `PPGU_IDX_ENABLE_LOWER, 8'h3C);
      acc(1'b1, `PPGU_IDX_NEXT_LOWER_SHARED, 8'hFF);
      trig(0);
      chk(porta_out, 8'h3C);
      chk(pin_a, 8'hFF);
      chk(portb_tpc_en, 8'hF0);
      chk(pin_b, 8'h12);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      acc(1'b0, `PPGU_IDX_ENABLE_UPPER, 8'h00);
      chk(q, 8'h00);
      chk(portb_out, 8'h00);
      chk(porta_out, 8'h00);
      chk(porta_tpc_en, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
